// ---- hw/ulsm_pkg.sv ----
package ulsm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] OFS_RX_HOLDING     = 8'h00;
    localparam logic [7:0] OFS_LINE_STATUS    = 8'h04;
    localparam logic [7:0] OFS_MODEM_CONTROL  = 8'h08;
    localparam logic [7:0] OFS_MODEM_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_FLOW_THRESHOLD = 8'h10;
    localparam logic [7:0] OFS_FIFO_TRIGGER   = 8'h14;

    ////////////////////////////////////////////////////////////////////////
    // line status field positions
    localparam int unsigned LS_FIFO_ERR   = 7;
    localparam int unsigned LS_TX_EMPTY   = 6;
    localparam int unsigned LS_THR_EMPTY  = 5;
    localparam int unsigned LS_BREAK      = 4;
    localparam int unsigned LS_FRAMING    = 3;
    localparam int unsigned LS_PARITY     = 2;
    localparam int unsigned LS_OVERRUN    = 1;
    localparam int unsigned LS_DATA_READY = 0;

    ////////////////////////////////////////////////////////////////////////
    // modem control field positions
    localparam int unsigned MC_CLK_SEL    = 7;
    localparam int unsigned MC_THRESH_EN  = 6;
    localparam int unsigned MC_XON_ANY    = 5;
    localparam int unsigned MC_LOOP       = 4;
    localparam int unsigned MC_IRQ_OP     = 3;
    localparam int unsigned MC_FIFO_RDY   = 2;
    localparam int unsigned MC_RTS        = 1;
    localparam int unsigned MC_DTR        = 0;
    localparam logic [7:0]  MC_GUARD_MASK = 8'hE0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] MODEM_CONTROL_RST  = 8'h00;
    localparam logic [7:0] FLOW_THRESHOLD_RST = 8'h00;
    localparam logic [7:0] FIFO_TRIGGER_RST   = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // fifo depth and prescale
    localparam int unsigned FIFO_DEPTH = 64;
    localparam int unsigned CNT_W      = 7;
    localparam logic [1:0]  PRESCALE_LAST = 2'h3;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic brk;
        logic framing;
        logic parity;
    } ulsm_rx_tags_type;

    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } ulsm_modem_pins_type;

    typedef struct packed {
        logic rx_pin;
        ulsm_modem_pins_type modem;
    } ulsm_pin_in_type;

endpackage

// ---- hw/ulsm_sync.sv ----
`timescale 1ns/1ps

// two-stage synchroniser for pin levels
module ulsm_sync #(
    parameter int unsigned WIDTH = 1
) (
    // clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } ulsm_sync_state_type;

    ulsm_sync_state_type state_ff;
    ulsm_sync_state_type nxt_state;

    // first stage is read only by the second
    always_comb begin
        nxt_state.meta   = async_in;
        nxt_state.stable = state_ff.meta;
    end

    // idle pin level is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign sync_out = state_ff.stable;

endmodule

// ---- hw/ulsm_prescale.sv ----
`timescale 1ns/1ps

// one-cycle enable at pclk or pclk/4 ahead of the baud divider
module ulsm_prescale (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic div4_sel,
    // enable pulse
    output logic      baud_clk_en
);

    typedef struct packed {
        logic [1:0] cnt;
        logic       en;
    } ulsm_prescale_state_type;

    ulsm_prescale_state_type state_ff;
    ulsm_prescale_state_type nxt_state;

    always_comb begin
        nxt_state = state_ff;
        if (!div4_sel) begin
            nxt_state.cnt = 2'h0;
            nxt_state.en  = 1'b1;
        end else begin
            nxt_state.cnt = state_ff.cnt + 2'h1;
            nxt_state.en  = (state_ff.cnt == ulsm_pkg::PRESCALE_LAST);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign baud_clk_en = state_ff.en;

endmodule

// ---- hw/ulsm_top.sv ----
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps

// Summary of operation
// - fifo error bit 7 high while any stored character carries an error.
// - bit 6 high only when holding and shift registers are both empty.
// - bit 5 high when holding register empty; host may load 64 bytes.
// - break flag at bit 4; the break character reads as byte 00.
// - bit 3 framing flag shows stop-bit error of head character.
// - bit 2 parity flag shows parity failure of head character.
// - overrun flag bit 1 set after receive overrun, else zero.
// - data-ready bit 0 high while receive fifo holds a character.
// - bits 4:2 come straight from head character tags, not stored.
// - status read leaves pointer; holding register read advances it.
// - modem control bit 7 selects clock divide by one or four.
// - threshold and trigger registers reachable only with bit 6 set.
// - modem control bit 5 enables resume on any character.
// - bit 4 clear means normal mode without loop-back.
// - loop-back routes control bits 3, 2, 0, 1 to status 7:4, tx to rx.
// - control bits 7:5 writable only while feature write enable set.
module ulsm_top (
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [ulsm_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [ulsm_pkg::DATA_W-1:0]   pwdata,
    output logic      [ulsm_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // receive fifo side
    input  wire logic                          rx_push,
    input  wire ulsm_pkg::ulsm_rx_tags_type    rx_push_tags,
    input  wire logic                          rx_fifo_clear,
    input  wire logic [ulsm_pkg::BYTE_W-1:0]   rx_head_data,
    input  wire ulsm_pkg::ulsm_rx_tags_type    rx_head_tags,
    input  wire logic                          rx_overrun,
    output logic                               rx_pop,
    // transmit side
    input  wire logic                          thr_empty,
    input  wire logic                          tsr_empty,
    input  wire logic                          tx_serial,
    output logic                               tx_push,
    output logic      [ulsm_pkg::BYTE_W-1:0]   tx_data,
    // feature write enable
    input  wire logic                          efr_wr_en,
    // pins
    input  wire ulsm_pkg::ulsm_pin_in_type     pins_in,
    output logic                               tx_pin,
    output logic                               rts_n,
    output logic                               dtr_n,
    // to receiver, flow control and baud logic
    output logic                               rx_line,
    output logic      [3:0]                    modem_status_hi,
    output logic                               baud_clk_en,
    output logic                               xon_any_en,
    output logic      [ulsm_pkg::BYTE_W-1:0]   flow_threshold,
    output logic      [ulsm_pkg::BYTE_W-1:0]   fifo_trigger
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                          pready;
        logic                          pslverr;
        logic [ulsm_pkg::DATA_W-1:0]   prdata;
        logic                          rx_pop;
        logic                          tx_push;
        logic [ulsm_pkg::BYTE_W-1:0]   tx_data;
        logic [ulsm_pkg::BYTE_W-1:0]   mctl;
        logic [ulsm_pkg::BYTE_W-1:0]   flow_thr;
        logic [ulsm_pkg::BYTE_W-1:0]   fifo_trig;
        logic                          overrun;
        logic [ulsm_pkg::CNT_W-1:0]    rx_cnt;
        logic [ulsm_pkg::CNT_W-1:0]    err_cnt;
        logic                          thr_empty;
        logic                          tx_empty;
        logic                          tx_pin;
        logic                          rts_n;
        logic                          dtr_n;
        logic                          rx_line;
        logic [3:0]                    msr_hi;
        logic                          xon_any;
    } ulsm_state_type;

    ulsm_state_type state_ff;
    ulsm_state_type nxt_state;

    ulsm_pkg::ulsm_pin_in_type pins_sync;

    logic                        setup_phase;
    logic                        done_phase;
    logic                        wr_done;
    logic                        loop_on;
    logic                        thresh_open;
    logic                        head_err;
    logic                        push_err;
    logic [ulsm_pkg::BYTE_W-1:0] line_status;
    logic [ulsm_pkg::BYTE_W-1:0] wbyte;
    logic [ulsm_pkg::BYTE_W-1:0] rbyte;
    logic                        addr_hit;

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser and clock prescaler

    ulsm_sync #(
        .WIDTH ($bits(ulsm_pkg::ulsm_pin_in_type))
    ) u_pin_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins_in),
        .sync_out (pins_sync)
    );

    ulsm_prescale u_prescale (
        .pclk        (pclk),
        .presetn     (presetn),
        .div4_sel    (state_ff.mctl[ulsm_pkg::MC_CLK_SEL]),
        .baud_clk_en (baud_clk_en)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode helpers

    // answer is prepared in the setup cycle, so access never waits
    assign setup_phase = psel && !penable;
    assign done_phase  = psel && penable && state_ff.pready;
    assign wr_done     = done_phase && pwrite && !state_ff.pslverr;
    assign wbyte       = pwdata[ulsm_pkg::BYTE_W-1:0];
    assign loop_on     = state_ff.mctl[ulsm_pkg::MC_LOOP];
    assign thresh_open = state_ff.mctl[ulsm_pkg::MC_THRESH_EN];
    assign head_err    = |rx_head_tags;
    assign push_err    = |rx_push_tags;

    // status byte as a read sees it; head tags are wired, not held
    always_comb begin
        line_status = '0;
        line_status[ulsm_pkg::LS_FIFO_ERR] = (state_ff.err_cnt != '0);
        line_status[ulsm_pkg::LS_TX_EMPTY] = state_ff.tx_empty;
        line_status[ulsm_pkg::LS_THR_EMPTY] = state_ff.thr_empty;
        line_status[ulsm_pkg::LS_BREAK] = rx_head_tags.brk;
        line_status[ulsm_pkg::LS_FRAMING] = rx_head_tags.framing;
        line_status[ulsm_pkg::LS_PARITY] = rx_head_tags.parity;
        line_status[ulsm_pkg::LS_OVERRUN] = state_ff.overrun;
        line_status[ulsm_pkg::LS_DATA_READY] = (state_ff.rx_cnt != '0);
    end

    // read mux; gated threshold registers read as zero
    always_comb begin
        rbyte    = '0;
        addr_hit = 1'b1;
        unique case (paddr)
            ulsm_pkg::OFS_RX_HOLDING: begin
                // break character reads as zero byte
                rbyte = rx_head_tags.brk ? 8'h00 : rx_head_data;
            end
            ulsm_pkg::OFS_LINE_STATUS: begin
                rbyte = line_status;
            end
            ulsm_pkg::OFS_MODEM_CONTROL: begin
                rbyte = state_ff.mctl;
            end
            ulsm_pkg::OFS_MODEM_STATUS: begin
                rbyte = {state_ff.msr_hi, 4'h0};
            end
            ulsm_pkg::OFS_FLOW_THRESHOLD: begin
                rbyte = thresh_open ? state_ff.flow_thr : 8'h00;
            end
            ulsm_pkg::OFS_FIFO_TRIGGER: begin
                rbyte = thresh_open ? state_ff.fifo_trig : 8'h00;
            end
            default: begin
                addr_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_state = state_ff;

        // bus answer
        nxt_state.pready  = setup_phase;
        if (setup_phase) begin
            nxt_state.pslverr = !addr_hit;
            nxt_state.prdata  = '0;
            if (!pwrite) begin
                nxt_state.prdata[ulsm_pkg::BYTE_W-1:0] = rbyte;
            end
        end else if (done_phase) begin
            nxt_state.pslverr = 1'b0;
        end

        // only a holding register read advances the pointer
        nxt_state.rx_pop = done_phase && !pwrite && !state_ff.pslverr &&
                           (paddr == ulsm_pkg::OFS_RX_HOLDING) &&
                           (state_ff.rx_cnt != '0);

        // writes to the holding register feed the transmit fifo
        nxt_state.tx_push = wr_done && (paddr == ulsm_pkg::OFS_RX_HOLDING);
        if (nxt_state.tx_push) begin
            nxt_state.tx_data = wbyte;
        end

        if (wr_done && (paddr == ulsm_pkg::OFS_MODEM_CONTROL)) begin
            nxt_state.mctl[4:0] = wbyte[4:0];
            if (efr_wr_en) begin
                nxt_state.mctl[7:5] = wbyte[7:5];
            end
        end

        if (wr_done && thresh_open &&
            (paddr == ulsm_pkg::OFS_FLOW_THRESHOLD)) begin
            nxt_state.flow_thr = wbyte;
        end
        if (wr_done && thresh_open &&
            (paddr == ulsm_pkg::OFS_FIFO_TRIGGER)) begin
            nxt_state.fifo_trig = wbyte;
        end

        // read of status clears, a new overrun wins
        if (done_phase && !pwrite &&
            (paddr == ulsm_pkg::OFS_LINE_STATUS)) begin
            nxt_state.overrun = 1'b0;
        end
        if (rx_overrun) begin
            nxt_state.overrun = 1'b1;
        end

        // character count follows pushes and pops
        // error count follows tagged pushes and pops
        if (rx_fifo_clear) begin
            nxt_state.rx_cnt  = '0;
            nxt_state.err_cnt = '0;
        end else begin
            nxt_state.rx_cnt  = state_ff.rx_cnt
                              + ulsm_pkg::CNT_W'(rx_push)
                              - ulsm_pkg::CNT_W'(state_ff.rx_pop);
            nxt_state.err_cnt = state_ff.err_cnt
                              + ulsm_pkg::CNT_W'(rx_push && push_err)
                              - ulsm_pkg::CNT_W'(state_ff.rx_pop &&
                                                 head_err &&
                                                 state_ff.err_cnt != '0);
        end

        nxt_state.tx_empty  = thr_empty && tsr_empty;
        nxt_state.thr_empty = thr_empty;

        nxt_state.xon_any = state_ff.mctl[ulsm_pkg::MC_XON_ANY];

        if (loop_on) begin
            // internal loop-back, line pins parked idle
            nxt_state.rx_line = tx_serial;
            nxt_state.tx_pin  = 1'b1;
            nxt_state.rts_n   = 1'b1;
            nxt_state.dtr_n   = 1'b1;
            nxt_state.msr_hi  = {state_ff.mctl[ulsm_pkg::MC_IRQ_OP],
                                 state_ff.mctl[ulsm_pkg::MC_FIFO_RDY],
                                 state_ff.mctl[ulsm_pkg::MC_DTR],
                                 state_ff.mctl[ulsm_pkg::MC_RTS]};
        end else begin
            nxt_state.rx_line = pins_sync.rx_pin;
            nxt_state.tx_pin  = tx_serial;
            nxt_state.rts_n   = !state_ff.mctl[ulsm_pkg::MC_RTS];
            nxt_state.dtr_n   = !state_ff.mctl[ulsm_pkg::MC_DTR];
            nxt_state.msr_hi  = ~pins_sync.modem;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff           <= '0;
            state_ff.mctl      <= ulsm_pkg::MODEM_CONTROL_RST;
            state_ff.flow_thr  <= ulsm_pkg::FLOW_THRESHOLD_RST;
            state_ff.fifo_trig <= ulsm_pkg::FIFO_TRIGGER_RST;
            state_ff.thr_empty <= 1'b1;
            state_ff.tx_empty  <= 1'b1;
            state_ff.tx_pin    <= 1'b1;
            state_ff.rts_n     <= 1'b1;
            state_ff.dtr_n     <= 1'b1;
            state_ff.rx_line   <= 1'b1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign prdata          = state_ff.prdata;
    assign pready          = state_ff.pready;
    assign pslverr         = state_ff.pslverr;
    assign rx_pop          = state_ff.rx_pop;
    assign tx_push         = state_ff.tx_push;
    assign tx_data         = state_ff.tx_data;
    assign tx_pin          = state_ff.tx_pin;
    assign rts_n           = state_ff.rts_n;
    assign dtr_n           = state_ff.dtr_n;
    assign rx_line         = state_ff.rx_line;
    assign modem_status_hi = state_ff.msr_hi;
    assign xon_any_en      = state_ff.xon_any;
    assign flow_threshold  = state_ff.flow_thr;
    assign fifo_trigger    = state_ff.fifo_trig;

endmodule

// ---- testbench/ulsm_checker.sv ----
`timescale 1ns/1ps

// watches the register block at its own ports
module ulsm_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // fifo, transmitter and control
    input wire logic [2:0]  rx_head_tags,
    input wire logic        rx_overrun,
    input wire logic        rx_pop,
    input wire logic        thr_empty,
    input wire logic        tsr_empty,
    input wire logic        efr_wr_en,
    input wire logic        xon_any_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    logic ls;
    assign rd = psel && !penable && !pwrite;
    assign ls = rd && paddr == ulsm_pkg::OFS_LINE_STATUS;
    ////////////////////////////////////////////////////////////////////////
    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    property p_unmapped;
        psel && !penable && paddr > 8'h14 |=> pslverr && prdata == 0;
    endproperty
    property p_no_pop; ls |=> ##1 !rx_pop; endproperty
    property p_pop_cause;
        rx_pop |-> $past(rd && paddr == ulsm_pkg::OFS_RX_HOLDING, 2);
    endproperty
    // empty flags are registered once before the status snapshot
    property p_tx_empty;
        ls |=> prdata[6] == $past(thr_empty && tsr_empty, 2);
    endproperty
    property p_thr_empty; ls |=> prdata[5] == $past(thr_empty, 2); endproperty
    property p_head_tags;
        ls |=> prdata[0] |-> prdata[4:2] == $past(rx_head_tags);
    endproperty
    property p_break_zero;
        rd && paddr == ulsm_pkg::OFS_RX_HOLDING && rx_head_tags[2]
        |=> prdata[7:0] == 8'h00;
    endproperty
    property p_overrun; ls && $past(rx_overrun) |=> prdata[1]; endproperty
    property p_guard;
        psel && !penable && pwrite && !efr_wr_en
        && paddr == ulsm_pkg::OFS_MODEM_CONTROL |=> ##1 $stable(xon_any_en)[*3];
    endproperty
    a_answer: assert property (p_answer) else $error("no one-cycle answer");
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    a_no_pop: assert property (p_no_pop) else $error("status read popped");
    a_pop_cause: assert property (p_pop_cause) else $error("stray pop");
    a_tx_empty: assert property (p_tx_empty) else $error("tx empty bad");
    a_thr_empty: assert property (p_thr_empty) else $error("thr flag bad");
    a_head_tags: assert property (p_head_tags) else $error("tags bad");
    a_break_zero: assert property (p_break_zero) else $error("break byte");
    a_overrun: assert property (p_overrun) else $error("overrun lost");
    a_guard: assert property (p_guard) else $error("guarded bits moved");
    c_fifo_err: cover property (ls ##1 prdata[7]);
    c_pop: cover property (rx_pop);
    c_slverr: cover property (pslverr);
endmodule

bind ulsm_top ulsm_checker u_chk (.*);

// ---- testbench/ulsm_far_model.sv ----
`timescale 1ns/1ps

// receive fifo and transmitter standing beside the register block
module ulsm_far_model (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // receive fifo
    input  wire logic       rx_push,
    input  wire logic [2:0] rx_push_tags,
    input  wire logic [7:0] rx_push_data,
    input  wire logic       rx_fifo_clear,
    input  wire logic       rx_pop,
    output logic [2:0]      rx_head_tags,
    output logic [7:0]      rx_head_data,
    // transmitter
    input  wire logic       tx_push,
    output logic            thr_empty,
    output logic            tsr_empty,
    output logic            tx_serial
);
    logic [10:0] q [$];
    logic [10:0] last;
    int          busy;
    // empty fifo shows the inverse of the last head
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.delete();
            last = 11'h000;
            busy = 0;
        end else begin
            if (rx_pop && q.size() > 0) begin
                void'(q.pop_front());
            end
            if (rx_fifo_clear) begin
                q.delete();
            end else if (rx_push) begin
                q.push_back({rx_push_tags, rx_push_data});
            end
            busy = tx_push ? 12 : (busy > 0 ? busy - 1 : 0);
        end
        if (q.size() > 0) begin
            last = q[0];
        end
        {rx_head_tags, rx_head_data} <= (q.size() > 0) ? q[0] : ~last;
        thr_empty <= busy <= 8;
        tsr_empty <= busy == 0;
        tx_serial <= (busy == 0) | busy[0];
    end
endmodule

// ---- testbench/uart_line_status_modem_control_tb_top.sv ----
`timescale 1ns/1ps

module uart_line_status_modem_control_tb_top;
    localparam logic [7:0] LS = ulsm_pkg::OFS_LINE_STATUS;
    localparam logic [7:0] MC = ulsm_pkg::OFS_MODEM_CONTROL;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        pready, pslverr, err, rx_push, rx_pop;
    logic        rx_fifo_clear, rx_overrun, thr_empty;
    logic        tsr_empty, tx_serial, tx_push, efr_wr_en;
    logic        tx_pin, rts_n, dtr_n, rx_line;
    logic        baud_clk_en, xon_any_en;
    logic [7:0]  paddr, rx_push_data, rx_head_data, tx_data;
    logic [7:0]  flow_threshold, fifo_trigger;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  modem_status_hi;
    logic [2:0]  rx_push_tags, rx_head_tags;
    logic [4:0]  pins_in;
    int          failures, tests_run;

    ulsm_top dut (.*);
    ulsm_far_model far (.*);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // entered just after a rising edge; leaves psel up for a following setup
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        if (pready !== 1'b1) begin
            failures++;
            close_out();
        end
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic settle_pins(input logic [2:0] exp);
        idle(1);
        @(negedge pclk);
        chk({tx_pin, rts_n, dtr_n}, exp);
        @(posedge pclk);
    endtask
    task automatic baud_count(input logic xon, input int exp);
        int cnt;
        idle(2);
        @(negedge pclk);
        chk(xon_any_en, xon);
        cnt = 0;
        repeat (16) begin
            @(negedge pclk);
            cnt += baud_clk_en;
        end
        chk(cnt, exp);
        @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(0, LS, 0);
        chk(rd & 32'hE3, 32'h60);
        apb(0, MC, 0);
        chk(rd, 32'h0);
        idle(1);
        $display("test reset done");
    endtask
    task automatic t_rx;
        logic [10:0] tbl [4];
        tbl = '{11'h041, 11'h142, 11'h246, 11'h455};
        for (int i = 0; i < 4; i++) begin
            rx_push <= 1'b1;
            {rx_push_tags, rx_push_data} <= tbl[i];
            @(posedge pclk);
        end
        rx_push <= 1'b0;
        @(posedge pclk);
        // status first, then the character it describes
        for (int i = 0; i < 4; i++) begin
            apb(0, LS, 0);
            chk(rd & 32'h9F, {1'b1, 2'b00, tbl[i][10:8], 2'b01});
            apb(0, LS, 0);
            chk(rd[4:0], {tbl[i][10:8], 2'b01});
            apb(0, ulsm_pkg::OFS_RX_HOLDING, 0);
            chk(rd, (i == 3) ? 32'h0 : 32'(tbl[i][7:0]));
            idle(2);
        end
        apb(0, LS, 0);
        chk(rd & 32'h81, 32'h0);
        idle(1);
        $display("test receive errors done");
    endtask
    task automatic t_ovr;
        rx_overrun <= 1'b1;
        @(posedge pclk);
        rx_overrun <= 1'b0;
        apb(0, LS, 0);
        chk(rd[1], 1'b1);
        apb(0, LS, 0);
        chk(rd[1], 1'b0);
        idle(1);
        $display("test overrun done");
    endtask
    task automatic t_tx;
        int n;
        apb(1, ulsm_pkg::OFS_RX_HOLDING, 32'h5A);
        idle(2);
        apb(0, LS, 0);
        chk(rd & 32'h60, 32'h0);
        n = 0;
        do begin
            apb(0, LS, 0);
            n++;
        end while (rd[5] !== 1'b1 && n < 20);
        chk(rd & 32'h60, 32'h20);
        idle(12);
        apb(0, LS, 0);
        chk(rd & 32'h60, 32'h60);
        idle(1);
        $display("test transmit flags done");
    endtask
    task automatic t_mctl;
        logic [7:0] a;
        apb(1, MC, 32'hFF);
        apb(0, MC, 0);
        chk(rd, 32'h1F);
        efr_wr_en <= 1'b1;
        apb(1, MC, 32'hE0);
        apb(0, MC, 0);
        chk(rd, 32'hE0);
        baud_count(1'b1, 4);
        for (int j = 0; j < 2; j++) begin
            a = j ? ulsm_pkg::OFS_FIFO_TRIGGER : ulsm_pkg::OFS_FLOW_THRESHOLD;
            apb(1, MC, 32'h40);
            apb(1, a, 32'h33 + j);
            apb(1, MC, 32'h00);
            apb(1, a, 32'h77);
            apb(0, a, 0);
            chk(rd, 32'h0);
            apb(1, MC, 32'h40);
            apb(0, a, 0);
            chk(rd, 32'h33 + j);
        end
        apb(1, MC, 32'h00);
        baud_count(1'b0, 16);
        $display("test modem control done");
    endtask
    task automatic t_loop;
        efr_wr_en <= 1'b0;
        pins_in <= 5'b10101;
        apb(1, MC, 32'h1B);
        idle(4);
        apb(0, ulsm_pkg::OFS_MODEM_STATUS, 0);
        chk(rd, 32'hB0);
        settle_pins(3'b111);
        apb(1, MC, 32'h03);
        idle(4);
        apb(0, ulsm_pkg::OFS_MODEM_STATUS, 0);
        chk(rd, 32'hA0);
        apb(0, 8'h18, 0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
        settle_pins({tx_serial, 2'b00});
        $display("test loop-back done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        failures = 0;
        tests_run = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, rx_push, rx_fifo_clear} = '0;
        {rx_overrun, efr_wr_en, paddr, pwdata} = '0;
        {rx_push_tags, rx_push_data} = '0;
        pins_in = 5'h1F;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_reset();
        t_rx();
        t_ovr();
        t_tx();
        t_mctl();
        t_loop();
        close_out();
    end
endmodule
